// ---- hw/flash_key_margin.sv ----
// Key verify and margin level command sequencer with Wishbone registers
// Function
// R1 - Software loads code 0x0C at index 0 and keys 0..3 at indices 1..4
// R2 - Key verify flags access error unless index is exactly 4
// R3 - Key verify runs only when key enable field equals binary 10
// R4 - Supplied keys compared with stored key; full match releases security
// R5 - Mismatch keeps security, flags error, locks out key verify until reset
// R6 - Command complete flag sets after key verify, match or not
// R7 - Software must not run key verify from the block holding the key
// R8 - Software loads 0x0D plus block code at index 0, setting at 1
// R9 - User margin accepts settings 0, 1 and 2
// R10 - Valid margin command stores level for block, then sets complete
// R11 - EEPROM margin affects EEPROM only; flash margin affects both (EEPROM reads use the flash level only while the EEPROM level is normal)
// R12 - Margin commands flag error unless index is 1
// R13 - Margin commands flag error for an invalid block code
// R14 - Margin commands flag error for an out-of-range setting
// R15 - Margin commands flag error when not available in current mode
// R16 - Field margin code 0x0E accepted only in special modes
// R17 - Field margin also accepts settings 3 and 4
// R18 - Software uses field margin only for factory programming verify
// R19 - Stored margin levels persist and return to normal on reset
`timescale 1ns/10ps
`default_nettype none
module flash_key_margin (
    // Clock and reset
    input  wire  logic                       clk_i,
    input  wire  logic                       rst_i,
    input  wire  logic                       ce_i,
    // Wishbone slave
    input  wire  logic                       cyc_i,
    input  wire  logic                       stb_i,
    input  wire  flash_cmd_pkg::wb_req_type  req_i,
    output logic [31:0]                      dat_o,
    output logic                             ack_o,
    // Device state
    input  wire  logic [1:0]                 backdoor_key_enable_i,
    input  wire  logic                       special_mode_i,
    input  wire  logic [63:0]                stored_key_i,
    // Outputs
    output logic [17:0]                      key_addr_o,
    output logic                             secured_o,
    output logic [2:0]                       eeprom_read_margin_o,
    output logic [2:0]                       pflash_read_margin_o,
    output logic                             irq_o
);
    import flash_cmd_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} state_type;

    // Pin synchronisers
    logic [1:0] key_enable_s1_q, key_enable_s2_q;
    logic       special_s1_q, special_s2_q;

    // Registers
    state_type          state_q, state_d;
    logic [2:0]         param_word_index_q;
    logic [15:0]        command_param_words_q [0:7];
    logic               command_complete_flag_q;
    logic               access_error_flag_q;
    logic               secured_q;
    logic               key_lockout_q;
    margin_type         margin_q;
    logic [IRQ_W-1:0]   irq_stat_q;
    logic [IRQ_W-1:0]   irq_mask_q;
    logic               ack_q;
    logic [31:0]        dat_q;
    logic               irq_q;
    logic [63:0]        stored_key_q;
    result_type         result_q;

    // Bus decode
    logic        bus_req, wr_stb, rd_stb;
    logic [31:0] rd_mux;
    logic        launch;
    assign bus_req = cyc_i && stb_i && !ack_q;
    assign wr_stb  = bus_req && req_i.we && req_i.sel[0];
    assign rd_stb  = bus_req && !req_i.we;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = a == off;
    endfunction

    // Launch: writing one to the complete flag while it is set clears it
    assign launch = wr_stb && hit(req_i.adr, ADDR_STATUS)
                    && req_i.dat[STAT_CCF] && command_complete_flag_q;

    // Command decode
    logic [7:0]  cmd_code;
    logic [1:0]  block_select_code;
    logic [15:0] setting;
    logic        is_key, is_user, is_field, is_margin;
    assign cmd_code          = command_param_words_q[0][15:8];
    assign block_select_code = command_param_words_q[0][1:0];
    assign setting           = command_param_words_q[1];
    assign is_key   = cmd_code == CMD_KEY_VERIFY;   // R1
    assign is_user  = cmd_code == CMD_USER_MARGIN;  // R8
    assign is_field = cmd_code == CMD_FIELD_MARGIN;
    assign is_margin = is_user || is_field;

    // Key match
    logic [63:0] supplied_keys;
    logic        keys_match;
    assign supplied_keys = {command_param_words_q[4], command_param_words_q[3],
                            command_param_words_q[2], command_param_words_q[1]};
    key_compare u_key (
        .supplied_i (supplied_keys),
        .stored_i   (stored_key_q),
        .match_o    (keys_match)
    );

    // Margin validation
    logic       block_ok, setting_ok;
    logic [2:0] new_level;
    margin_check u_margin (
        .field_i      (is_field),
        .block_i      (block_select_code),
        .setting_i    (setting),
        .block_ok_o   (block_ok),
        .setting_ok_o (setting_ok),
        .level_o      (new_level)
    );

    // Error evaluation
    logic key_err, margin_err, mode_err, cmd_err, key_ok;
    assign key_err = (param_word_index_q != IDX_KEY_LAST)     // R2
                     || (key_enable_s2_q != KEY_ENABLE_ON)    // R3
                     || key_lockout_q;                        // R5
    assign key_ok  = is_key && !key_err && keys_match;        // R4
    assign mode_err = is_field && !special_s2_q;              // R15 R16
    assign margin_err = (param_word_index_q != IDX_MARGIN_LAST) // R12
                        || !block_ok                          // R13
                        || !setting_ok                        // R14 R9 R17
                        || mode_err;
    assign cmd_err = is_key ? (key_err || !keys_match) :      // R5
                     is_margin ? margin_err : 1'b1;

    // Sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (launch) state_d = ST_EXEC;
            ST_EXEC: state_d = ST_DONE;
            ST_DONE: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_enable_s1_q <= 2'h0;
            key_enable_s2_q <= 2'h0;
            special_s1_q    <= 1'b0;
            special_s2_q    <= 1'b0;
        end else if (ce_i) begin
            key_enable_s1_q <= backdoor_key_enable_i;
            key_enable_s2_q <= key_enable_s1_q;
            special_s1_q <= special_mode_i;
            special_s2_q <= special_s1_q;
        end
    end

    // Stored key sampled from the same-clock flash read path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stored_key_q <= 64'h0000_0000_0000_0000;
        end else if (ce_i) begin
            stored_key_q <= stored_key_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    // Flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            command_complete_flag_q <= 1'b1;
            access_error_flag_q     <= 1'b0;
            result_q                <= RES_DONE;
        end else if (ce_i) begin
            // Clear first, so an error raised in the same cycle still wins
            if (wr_stb && hit(req_i.adr, ADDR_STATUS) && req_i.dat[STAT_ACCESS_ERR]) begin
                access_error_flag_q <= 1'b0;
            end
            if (launch) begin
                command_complete_flag_q <= 1'b0;
                access_error_flag_q     <= 1'b0;
            end else if (state_q == ST_EXEC) begin
                access_error_flag_q <= cmd_err;
                result_q <= cmd_err ? RES_ERR : (key_ok ? RES_UNSEC : RES_DONE);
            end else if (state_q == ST_DONE) begin
                command_complete_flag_q <= 1'b1; // R6 R10
            end
        end
    end

    // Security and lockout
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            secured_q     <= 1'b1;
            key_lockout_q <= 1'b0;
        end else if (ce_i && state_q == ST_EXEC && is_key && !key_err) begin
            if (keys_match) begin
                secured_q <= 1'b0; // R4
            end else begin
                key_lockout_q <= 1'b1; // R5
            end
        end
    end

    // Margin levels, normal after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            margin_q <= '0; // R19
        end else if (ce_i && state_q == ST_EXEC && is_margin && !margin_err) begin
            if (block_select_code == BLK_EEPROM) begin
                margin_q.eeprom <= new_level; // R10
            end else begin
                margin_q.pflash <= new_level; // R10
            end
        end
    end

    // Parameter words and index; parameter word writes ignored while a command runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            param_word_index_q <= 3'h0;
        end else if (ce_i && wr_stb && hit(req_i.adr, ADDR_INDEX)) begin
            param_word_index_q <= req_i.dat[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i && wr_stb && hit(req_i.adr, ADDR_PARAM) && command_complete_flag_q) begin
            command_param_words_q[param_word_index_q] <= req_i.dat[15:0];
        end
    end

    // Interrupts: set wins over write-one-to-clear
    logic [IRQ_W-1:0] irq_set, irq_clr;
    assign irq_set = {result_q == RES_UNSEC, result_q == RES_ERR, 1'b1}
                     & {IRQ_W{state_q == ST_DONE}};
    assign irq_clr = (wr_stb && hit(req_i.adr, ADDR_IRQ_STAT)) ? req_i.dat[IRQ_W-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq_q      <= 1'b0;
        end else if (ce_i) begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            if (wr_stb && hit(req_i.adr, ADDR_IRQ_MASK)) begin
                irq_mask_q <= req_i.dat[IRQ_W-1:0];
            end
            irq_q <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
        end
    end

    // Read mux
    always_comb begin
        rd_mux = RST_ZERO;
        unique case (req_i.adr)
            ADDR_CTRL:     rd_mux = {16'h0000, command_param_words_q[0]};
            ADDR_INDEX:    rd_mux = {29'h0000_0000, param_word_index_q};
            ADDR_PARAM:    rd_mux = {16'h0000, command_param_words_q[param_word_index_q]};
            ADDR_STATUS:   rd_mux = {24'h00_0000, command_complete_flag_q, 1'b0,
                                     access_error_flag_q, 5'h00};
            ADDR_IRQ_STAT: rd_mux = {29'h0000_0000, irq_stat_q};
            ADDR_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask_q};
            ADDR_MARGIN:   rd_mux = {26'h000_0000, margin_q};
            ADDR_SECURITY: rd_mux = {24'h00_0000, key_enable_s2_q, 4'h0,
                                     key_lockout_q, secured_q};
            default:       rd_mux = RST_ZERO;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= RST_ZERO;
        end else if (ce_i) begin
            ack_q <= bus_req;
            dat_q <= rd_stb ? rd_mux : RST_ZERO;
        end
    end

    // Margin applied to reads: flash margin covers eeprom when eeprom is normal
    logic [2:0] eep_q, pfl_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eep_q <= 3'h0;
            pfl_q <= 3'h0;
        end else if (ce_i) begin
            pfl_q <= margin_q.pflash; // R11
            eep_q <= (margin_q.eeprom != 3'h0) ? margin_q.eeprom : margin_q.pflash; // R11
        end
    end

    logic [17:0] key_addr_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_addr_q <= KEY_STORE_ADDR;
        end else begin
            key_addr_q <= KEY_STORE_ADDR;
        end
    end

    assign dat_o                = dat_q;
    assign ack_o                = ack_q;
    assign secured_o            = secured_q;
    assign irq_o                = irq_q;
    assign key_addr_o           = key_addr_q;
    assign eeprom_read_margin_o = eep_q;
    assign pflash_read_margin_o = pfl_q;

    // Checks
    chk_key_index_err: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        ce_i && state_q == ST_EXEC && is_key && param_word_index_q != IDX_KEY_LAST
        |=> access_error_flag_q)
        else $error("key verify with bad index did not flag error");
    chk_key_enable: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        ce_i && state_q == ST_EXEC && is_key && key_enable_s2_q != KEY_ENABLE_ON
        |=> access_error_flag_q && $stable(secured_q))
        else $error("key verify ran while disabled");
    chk_key_release: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        $fell(secured_q) |-> $past(is_key) && $past(keys_match))
        else $error("security released without key match");
    chk_key_lockout: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        key_lockout_q |=> key_lockout_q && $stable(secured_q))
        else $error("lockout cleared without reset");
    chk_done_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        ce_i && state_q == ST_EXEC ##1 ce_i |=> command_complete_flag_q)
        else $error("complete flag not set after command");
    chk_margin_index: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        ce_i && state_q == ST_EXEC && is_margin && param_word_index_q != IDX_MARGIN_LAST
        |=> access_error_flag_q && $stable(margin_q))
        else $error("margin with bad index accepted");
    chk_field_mode: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        ce_i && state_q == ST_EXEC && is_field && !special_s2_q
        |=> access_error_flag_q)
        else $error("field margin accepted outside special mode");
    chk_user_setting: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        ce_i && state_q == ST_EXEC && is_user && setting > MRG_USER_MAX
        |=> access_error_flag_q)
        else $error("user margin accepted field setting");
    cov_key_unsecure: cover property (@(posedge clk_i) $fell(secured_q));
    cov_lockout:      cover property (@(posedge clk_i) $rose(key_lockout_q));
    cov_margin_set:   cover property (@(posedge clk_i) $changed(margin_q));
endmodule
`default_nettype wire

// ---- hw/flash_cmd_pkg.sv ----
// Package: register map, command codes, margin encodings and carriers
package flash_cmd_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_INDEX    = 8'h04;
    localparam logic [7:0] ADDR_PARAM    = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_MARGIN   = 8'h18;
    localparam logic [7:0] ADDR_KEY_BASE = 8'h20;
    localparam logic [7:0] ADDR_SECURITY = 8'h30;
    // Status bit positions
    localparam int STAT_CCF    = 7;
    localparam int STAT_ACCESS_ERR = 5;
    // Interrupt status bit positions
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_ERR     = 1;
    localparam int IRQ_UNSEC   = 2;
    // Security register bit positions
    localparam int SEC_KEY_ENABLE_LO = 6;
    localparam int SEC_SECURED  = 0;
    // Command codes
    localparam logic [7:0] CMD_KEY_VERIFY  = 8'h0C;
    localparam logic [7:0] CMD_USER_MARGIN = 8'h0D;
    localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
    // Parameter word index values
    localparam logic [2:0] IDX_KEY_LAST    = 3'h4;
    localparam logic [2:0] IDX_MARGIN_LAST = 3'h1;
    // Backdoor key enable value
    localparam logic [1:0] KEY_ENABLE_ON = 2'h2;
    // Margin settings
    localparam logic [15:0] MRG_NORMAL   = 16'h0000;
    localparam logic [15:0] MRG_USER_MAX = 16'h0002;
    localparam logic [15:0] MRG_FIELD_MAX = 16'h0004;
    // Block codes
    localparam logic [1:0] BLK_EEPROM = 2'h0;
    localparam logic [1:0] BLK_PFLASH = 2'h1;
    // Key words, stored key base address
    localparam int NUM_KEYS = 4;
    localparam logic [17:0] KEY_STORE_ADDR = 18'h3_FF00;
    // Reset values and interrupt status width
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [2:0]  IRQ_W    = 3;

    typedef struct packed {
        logic [7:0]  adr;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic [2:0] eeprom;
        logic [2:0] pflash;
    } margin_type;

    typedef enum logic [1:0] {
        RES_DONE,
        RES_ERR,
        RES_UNSEC
    } result_type;
endpackage

// ---- hw/key_compare.sv ----
// Backdoor key comparison against stored comparison key
`timescale 1ns/10ps
`default_nettype none
module key_compare (
    // Keys
    input  wire  logic [63:0] supplied_i,
    input  wire  logic [63:0] stored_i,
    // Result
    output logic              match_o
);
    logic [3:0] word_eq;
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_word
            assign word_eq[k] = supplied_i[16*k +: 16] == stored_i[16*k +: 16];
        end
    endgenerate
    assign match_o = &word_eq;
endmodule
`default_nettype wire

// ---- hw/margin_check.sv ----
// Margin command argument validation and level encoding
`timescale 1ns/10ps
`default_nettype none
module margin_check
    import flash_cmd_pkg::*;
(
    // Command arguments
    input  wire  logic        field_i,
    input  wire  logic [1:0]  block_i,
    input  wire  logic [15:0] setting_i,
    // Result
    output logic              block_ok_o,
    output logic              setting_ok_o,
    output logic [2:0]        level_o
);
    assign block_ok_o   = (block_i == BLK_EEPROM) || (block_i == BLK_PFLASH);
    assign setting_ok_o = setting_i <= (field_i ? MRG_FIELD_MAX : MRG_USER_MAX);
    assign level_o      = setting_i[2:0];
endmodule
`default_nettype wire

// ---- testbench/flash_key_margin_test.sv ----
// Self-checking bench for the key verify and margin command sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_key_margin_test;
    import flash_cmd_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    wb_req_type  req_i = '0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [1:0]  backdoor_key_enable_i = 2'h0;
    logic        special_mode_i = 1'b0;
    logic [63:0] stored_key_i = 64'h0000_0000_0000_0000;
    logic [17:0] key_addr_o;
    logic        secured_o;
    logic [2:0]  eeprom_read_margin_o;
    logic [2:0]  pflash_read_margin_o;
    logic        irq_o;
    int          fail_count = 0;
    int          check_count = 0;
    int          cycles = 0;
    logic [15:0] lfsr = 16'h000A;
    logic [15:0] r;
    logic [2:0]  exp_e = 3'h0;
    logic [2:0]  exp_p = 3'h0;
    logic [31:0] rd;
    logic [31:0] st;
    logic [15:0] keys [4];

    flash_key_margin i_flash_key_margin (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .ce_i                  (ce_i),
        .cyc_i                 (cyc_i),
        .stb_i                 (stb_i),
        .req_i                 (req_i),
        .dat_o                 (dat_o),
        .ack_o                 (ack_o),
        .backdoor_key_enable_i (backdoor_key_enable_i),
        .special_mode_i        (special_mode_i),
        .stored_key_i          (stored_key_i),
        .key_addr_o            (key_addr_o),
        .secured_o             (secured_o),
        .eeprom_read_margin_o  (eeprom_read_margin_o),
        .pflash_read_margin_o  (pflash_read_margin_o),
        .irq_o                 (irq_o)
    );

    always #25 clk_i = ~clk_i;

    // Whole run is a little over a thousand cycles; generous ceiling
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic conclude();
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic draw();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        r = lfsr;
    endtask

    // EEPROM reads follow the flash level unless given their own
    function automatic logic [2:0] eff_e(input logic [2:0] e, input logic [2:0] p);
        return (e != 3'h0) ? e : p;
    endfunction

    // Classic cycle: hold until ack is sampled, then idle one cycle
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        req_i <= '{adr: a, we: w, sel: 4'hF, dat: d};
        // No local limit: only the bench timeout ends a stalled wait
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(a, 1'b1, d, rd);
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic run_cmd(input logic [15:0] w0, input int nw, input logic [2:0] idx);
        int n;
        wr(ADDR_STATUS, 32'h0000_0020);
        wr(ADDR_INDEX, 32'h0000_0000);
        wr(ADDR_PARAM, {16'h0000, w0});
        for (int i = 1; i <= nw; i++) begin
            wr(ADDR_INDEX, 32'(i));
            wr(ADDR_PARAM, {16'h0000, keys[i-1]});
        end
        wr(ADDR_INDEX, {29'h0000_0000, idx});
        wr(ADDR_STATUS, 32'h0000_0080);
        n = 0;
        do begin
            wb(ADDR_STATUS, 1'b0, 32'h0000_0000, st);
            n++;
        end while (st[STAT_CCF] !== 1'b1 && n < 30);
    endtask

    task automatic mrg(input logic fld, input logic [1:0] blk, input logic [15:0] set,
                       input logic [2:0] idx);
        logic err;
        err = (fld && !special_mode_i) || blk > BLK_PFLASH || idx != IDX_MARGIN_LAST
            || set > (fld ? MRG_FIELD_MAX : MRG_USER_MAX);
        keys[0] = set;
        run_cmd({fld ? CMD_FIELD_MARGIN : CMD_USER_MARGIN, 6'h00, blk}, 1, idx);
        if (!err && blk == BLK_EEPROM) exp_e = set[2:0];
        if (!err && blk == BLK_PFLASH) exp_p = set[2:0];
        chk("margin complete", 1, st[STAT_CCF]);
        chk("margin access error", err, st[STAT_ACCESS_ERR]);
        chk("eeprom level", eff_e(exp_e, exp_p), eeprom_read_margin_o);
        chk("pflash level", exp_p, pflash_read_margin_o);
    endtask

    // Only the last key is spoiled, so only the last word's comparison is exercised
    task automatic keyv(input logic [2:0] idx, input logic good, input logic err,
                        input logic sec);
        for (int i = 0; i < 4; i++) keys[i] = stored_key_i[16*i +: 16];
        if (!good) keys[3] = keys[3] ^ 16'h8000;
        run_cmd({CMD_KEY_VERIFY, 8'h00}, 4, idx);
        chk("key complete", 1, st[STAT_CCF]);
        chk("key access error", err, st[STAT_ACCESS_ERR]);
        chk("secured", sec, secured_o);
    endtask

    initial begin
        draw();
        stored_key_i <= {lfsr, ~lfsr, lfsr ^ 16'h5A5A, 16'h1234};
        do_reset();
        chk("reset secured", 1, secured_o);
        chk("key address", KEY_STORE_ADDR, key_addr_o);
        wb(8'h3C, 1'b0, 32'h0000_0000, rd);
        chk("unmapped read", 0, rd);
        // Mask bits enable their source; held off until the interrupt test
        wr(ADDR_IRQ_MASK, 32'h0000_0000);
        for (int b = 0; b < 2; b++) begin
            for (int s = 0; s < 4; s++) mrg(1'b0, 2'(b), 16'(s), IDX_MARGIN_LAST);
        end
        mrg(1'b0, 2'h2, 16'h0001, 3'h1);
        mrg(1'b0, 2'h3, 16'h0001, 3'h1);
        mrg(1'b0, 2'h1, 16'h0001, 3'h0);
        mrg(1'b0, 2'h1, 16'h0001, 3'h2);
        mrg(1'b1, 2'h1, 16'h0003, 3'h1);
        special_mode_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        mrg(1'b1, 2'h0, 16'h0003, 3'h1);
        mrg(1'b1, 2'h1, 16'h0004, 3'h1);
        mrg(1'b1, 2'h0, 16'h0005, 3'h1);
        for (int k = 0; k < 12; k++) begin
            draw();
            special_mode_i <= r[8];
            repeat (3) @(posedge clk_i);
            mrg(r[0], r[3:2], {13'h0000, r[6:4]}, (r[12:11] == 2'h0) ? 3'h0 : 3'h1);
        end
        mrg(1'b0, 2'h1, 16'h0002, 3'h1);
        wb(ADDR_MARGIN, 1'b0, 32'h0000_0000, rd);
        chk("stored levels", {26'h0, exp_e, exp_p}, rd);
        // Clock enable low: request held, no answer until it returns
        ce_i  <= 1'b0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        req_i <= '{adr: ADDR_MARGIN, we: 1'b0, sel: 4'hF, dat: 32'h0000_0000};
        repeat (4) @(posedge clk_i);
        chk("frozen ack", 0, ack_o);
        ce_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
        chk("frozen read", {26'h0, exp_e, exp_p}, rd);
        wb(ADDR_IRQ_STAT, 1'b0, 32'h0000_0000, rd);
        chk("irq done", 1, rd[IRQ_DONE]);
        chk("irq error", 1, rd[IRQ_ERR]);
        chk("irq masked", 0, irq_o);
        wr(ADDR_IRQ_MASK, 32'h0000_0007);
        repeat (2) @(posedge clk_i);
        chk("irq raised", 1, irq_o);
        wr(ADDR_IRQ_STAT, 32'h0000_0007);
        repeat (2) @(posedge clk_i);
        chk("irq cleared", 0, irq_o);
        backdoor_key_enable_i <= 2'h1;
        repeat (3) @(posedge clk_i);
        keyv(3'h4, 1'b1, 1'b1, 1'b1);
        backdoor_key_enable_i <= KEY_ENABLE_ON;
        repeat (3) @(posedge clk_i);
        keyv(3'h3, 1'b1, 1'b1, 1'b1);
        keyv(3'h4, 1'b0, 1'b1, 1'b1);
        keyv(3'h4, 1'b1, 1'b1, 1'b1);
        do_reset();
        exp_e = 3'h0;
        exp_p = 3'h0;
        chk("reset eeprom level", 0, eeprom_read_margin_o);
        chk("reset pflash level", 0, pflash_read_margin_o);
        keyv(3'h4, 1'b1, 1'b0, 1'b0);
        wb(ADDR_IRQ_STAT, 1'b0, 32'h0000_0000, rd);
        chk("irq unsecured", 32'h0000_0005, rd);
        conclude();
    end
endmodule
`default_nettype wire
